// file: dcib_motor_model.sv
// motor with brake contactor or freewheel path, watching the brake outputs
`timescale 1ns/1ps
`default_nettype none
module dcib_motor_model (
    input  wire logic       clock,
    input  wire logic       clr,
    input  wire logic       brake_relay,
    input  wire logic       scr_dc_on,
    input  wire logic [9:0] dc_level_ref,
    input  wire logic       extra_start_pulse,
    output var  int         pre_cnt,
    output var  int         inj_cnt,
    output var  int         post_cnt,
    output var  logic [9:0] lvl,
    output var  int         bad
);
    // ----------------------------------------
    // phase timing and level capture
    // ----------------------------------------
    logic relay_q;
    always @(posedge clock) begin
        relay_q <= brake_relay;
        if (clr) begin
            pre_cnt  <= 0;
            inj_cnt  <= 0;
            post_cnt <= 0;
            lvl      <= 10'h000;
            bad      <= 0;
        end else begin
            if (brake_relay && !scr_dc_on && inj_cnt == 0) pre_cnt <= pre_cnt + 1;
            if (scr_dc_on) inj_cnt <= inj_cnt + 1;
            if (scr_dc_on) lvl <= dc_level_ref;
            if (brake_relay && !scr_dc_on && inj_cnt > 0) post_cnt <= post_cnt + 1;
            if ((scr_dc_on && !brake_relay) || (!scr_dc_on && dc_level_ref != 10'h000)) bad <= bad + 1;
            if (extra_start_pulse !== (brake_relay && !relay_q)) bad <= bad + 1;
        end
    end
endmodule
`default_nettype wire

// file: dcib_params.svh
// constants of the dc injection brake sequencer
//
// Overview of operation
// - dc stop choice turns stop into braking
// - standard duty limits current to 250 percent
// - heavy duty allows up to 400 percent
// - each braking stop counts as extra start
// - one output relay drives the brake hardware
// - relay first, thyristors only after delay
// - inject only during brake time, relay held
// - relay hold grows with motor full-load current
// - overload stays active using running setting
// - overload told brake duty and feedback source
// - duty and feedback fixed at manufacture
// - brake delay spans stop to injection
// - brake time sets injection length
// - brake level sets regulated dc current
`ifndef DCIB_PARAMS_SVH
`define DCIB_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define DCIB_ADDR_CTRL      8'h00
`define DCIB_ADDR_DELAY     8'h04
`define DCIB_ADDR_TIME      8'h08
`define DCIB_ADDR_LEVEL     8'h0c
`define DCIB_ADDR_FLA       8'h10
`define DCIB_ADDR_STATUS    8'h14
`define DCIB_ADDR_STARTS    8'h18
`define DCIB_ADDR_HOLD      8'h1c

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DCIB_CTRL_RUN       0
`define DCIB_CTRL_DCSTOP    1
`define DCIB_ST_STATE_HI    2
`define DCIB_ST_RELAY       4
`define DCIB_ST_SCR         5
`define DCIB_ST_MOTOR       6
`define DCIB_ST_HEAVY       8
`define DCIB_ST_HALL        9
`define DCIB_RST_CTRL       2'h0
`define DCIB_RST_DELAY      16'h0064
`define DCIB_RST_TIME       16'h03e8
`define DCIB_RST_LEVEL      10'h0c8
`define DCIB_RST_FLA        11'h00a
`define DCIB_RESP_OKAY      2'h0
`define DCIB_RESP_SLVERR    2'h2

// ----------------------------------------
// current limits, percent of full-load current
// ----------------------------------------
`define DCIB_LIM_STD        10'h0fa
`define DCIB_LIM_HVY        10'h190

// ----------------------------------------
// hold after brake time versus full-load amps, in ms
// ----------------------------------------
`define DCIB_FLA_P0         32'h0000000a
`define DCIB_FLA_P1         32'h00000064
`define DCIB_FLA_P2         32'h000001f4
`define DCIB_FLA_P3         32'h000003e8
`define DCIB_HOLD_P0        32'h00000190
`define DCIB_HOLD_P1        32'h00000320
`define DCIB_HOLD_P2        32'h000008fc
`define DCIB_HOLD_P3        32'h000010cc

// ----------------------------------------
// timing
// ----------------------------------------
`define DCIB_CLK_NS         20
`define DCIB_MS_NS          1000000
`define DCIB_MS_CYCLES      (`DCIB_MS_NS / `DCIB_CLK_NS)
`define DCIB_STRAP_WAIT     2'h3

`endif

// file: dcib_pkg.sv
// types of the dc injection brake sequencer
package dcib_pkg;
    // ----------------------------------------
    // sequencer states, gray along the path except hold back to idle
    // ----------------------------------------
    typedef enum logic [2:0] {
        DCIB_IDLE   = 3'h0,
        DCIB_RUN    = 3'h1,
        DCIB_DELAY  = 3'h3,
        DCIB_INJECT = 3'h2,
        DCIB_HOLD   = 3'h6
    } dcib_state_t;
endpackage

// file: dcib_timer.sv
// millisecond down timer
`timescale 1ns/1ps
`default_nettype none
`include "dcib_params.svh"
module dcib_timer #(
    parameter int unsigned MS_CYCLES = `DCIB_MS_CYCLES
) (
    input  wire logic clock,
    input  wire logic resetn,
    dcib_tmr_if.tmr   t
);
    logic [15:0] pre_r;
    logic [15:0] cnt_r;
    logic        busy_r;
    logic        done_r;

    // ----------------------------------------
    // countdown
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pre_r  <= 16'h0000;
            cnt_r  <= 16'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (t.load) begin
            pre_r  <= 16'h0000;
            cnt_r  <= t.load_ms;
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end else if (busy_r && cnt_r == 16'h0000) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
        end else if (busy_r) begin
            done_r <= 1'b0;
            if (pre_r == 16'(MS_CYCLES - 1)) begin
                pre_r <= 16'h0000;
                cnt_r <= cnt_r - 16'h0001;
            end else begin
                pre_r <= pre_r + 16'h0001;
            end
        end else begin
            done_r <= 1'b0;
        end
    end

    assign t.busy = busy_r;
    assign t.done = done_r;

    AST_TMR_DONE_PULSE: assert property (@(posedge clock) disable iff (!resetn)
        done_r && !t.load |=> !done_r && !busy_r)
        else $error("timer done lasted more than one cycle");
endmodule
`default_nettype wire

// file: dcib_tmr_if.sv
// carrier between sequencer and millisecond timer
`timescale 1ns/1ps
`default_nettype none
interface dcib_tmr_if;
    logic        load;
    logic [15:0] load_ms;
    logic        busy;
    logic        done;
    modport ctrl (output load, output load_ms, input busy, input done);
    modport tmr  (input load, input load_ms, output busy, output done);
endinterface
`default_nettype wire

// file: dcib_top.sv
// dc injection brake sequencer with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "dcib_params.svh"
module dcib_top #(
    parameter int unsigned MS_CYCLES = `DCIB_MS_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        duty_heavy_strap,
    input  wire logic        hall_current_sensor_strap,
    output logic             brake_relay,
    output logic             scr_dc_on,
    output logic [9:0]       dc_level_ref,
    output logic             motor_run,
    output logic             extra_start_pulse,
    output logic             ol_use_running,
    output logic             ol_duty_heavy,
    output logic             ol_feedback_hall
);
    dcib_tmr_if tmr ();

    dcib_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
        .clock  (clock),
        .resetn (resetn),
        .t      (tmr.tmr)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic dcib_mapped(input logic [7:0] a);
        dcib_mapped = (a[1:0] == 2'h0) && (a <= `DCIB_ADDR_HOLD);
    endfunction

    function automatic logic [31:0] dcib_merge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        dcib_merge = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                dcib_merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    function automatic logic [15:0] dcib_hold_ms(input logic [10:0] fla);
        logic [31:0] f;
        logic [31:0] h;
        f = {21'h0, fla};
        if (f <= `DCIB_FLA_P0) begin
            h = `DCIB_HOLD_P0;
        end else if (f <= `DCIB_FLA_P1) begin
            h = `DCIB_HOLD_P0 + ((f - `DCIB_FLA_P0) * (`DCIB_HOLD_P1 - `DCIB_HOLD_P0))
                / (`DCIB_FLA_P1 - `DCIB_FLA_P0);
        end else if (f <= `DCIB_FLA_P2) begin
            h = `DCIB_HOLD_P1 + ((f - `DCIB_FLA_P1) * (`DCIB_HOLD_P2 - `DCIB_HOLD_P1))
                / (`DCIB_FLA_P2 - `DCIB_FLA_P1);
        end else begin
            h = `DCIB_HOLD_P2 + ((f - `DCIB_FLA_P2) * (`DCIB_HOLD_P3 - `DCIB_HOLD_P2))
                / (`DCIB_FLA_P3 - `DCIB_FLA_P2);
        end
        dcib_hold_ms = h[15:0];
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [1:0]  ctrl_r;
    logic [15:0] delay_ms_r;
    logic [15:0] time_ms_r;
    logic [9:0]  level_r;
    logic [10:0] fla_r;
    logic [15:0] hold_ms_r;
    logic [15:0] starts_r;
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;
    logic        wr_en;
    logic [31:0] rd_mux;
    logic [31:0] status_w;

    logic [1:0]  strap_s1_r;
    logic [1:0]  strap_s2_r;
    logic [1:0]  strap_cnt_r;
    logic        strap_done_r;
    logic        heavy_r;
    logic        hall_r;

    dcib_pkg::dcib_state_t state_r;
    dcib_pkg::dcib_state_t state_nxt;
    logic        relay_r;
    logic        scr_r;
    logic        motor_r;
    logic        extra_r;
    logic [9:0]  level_ref_r;
    logic [9:0]  level_lim;

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = !w_hold_r && !bvalid_r;
    assign wr_en         = aw_hold_r && w_hold_r && !bvalid_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `DCIB_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= dcib_mapped(awaddr_r) ? `DCIB_RESP_OKAY : `DCIB_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctrl_r     <= `DCIB_RST_CTRL;
            delay_ms_r <= `DCIB_RST_DELAY;
            time_ms_r  <= `DCIB_RST_TIME;
            level_r    <= `DCIB_RST_LEVEL;
            fla_r      <= `DCIB_RST_FLA;
        end else if (wr_en) begin
            if (awaddr_r == `DCIB_ADDR_CTRL) begin
                ctrl_r <= 2'(dcib_merge({30'h0, ctrl_r}, wdata_r, wstrb_r));
            end else if (awaddr_r == `DCIB_ADDR_DELAY) begin
                delay_ms_r <= 16'(dcib_merge({16'h0, delay_ms_r}, wdata_r, wstrb_r));
            end else if (awaddr_r == `DCIB_ADDR_TIME) begin
                time_ms_r <= 16'(dcib_merge({16'h0, time_ms_r}, wdata_r, wstrb_r));
            end else if (awaddr_r == `DCIB_ADDR_LEVEL) begin
                level_r <= 10'(dcib_merge({22'h0, level_r}, wdata_r, wstrb_r));
            end else if (awaddr_r == `DCIB_ADDR_FLA) begin
                fla_r <= 11'(dcib_merge({21'h0, fla_r}, wdata_r, wstrb_r));
            end
        end
    end

    // braking stops counter, increment wins over a clearing write
    always_ff @(posedge clock) begin
        if (!resetn) begin
            starts_r <= 16'h0000;
        end else if (extra_r) begin
            starts_r <= starts_r + 16'h0001;
        end else if (wr_en && awaddr_r == `DCIB_ADDR_STARTS) begin
            starts_r <= 16'h0000;
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    assign status_w = {22'h0, hall_r, heavy_r, 1'b0, motor_r, scr_r, relay_r, 1'b0, state_r};

    always_comb begin
        rd_mux = 32'h00000000;
        if (s_axi_araddr == `DCIB_ADDR_CTRL) begin
            rd_mux = {30'h0, ctrl_r};
        end else if (s_axi_araddr == `DCIB_ADDR_DELAY) begin
            rd_mux = {16'h0, delay_ms_r};
        end else if (s_axi_araddr == `DCIB_ADDR_TIME) begin
            rd_mux = {16'h0, time_ms_r};
        end else if (s_axi_araddr == `DCIB_ADDR_LEVEL) begin
            rd_mux = {22'h0, level_r};
        end else if (s_axi_araddr == `DCIB_ADDR_FLA) begin
            rd_mux = {21'h0, fla_r};
        end else if (s_axi_araddr == `DCIB_ADDR_STATUS) begin
            rd_mux = status_w;
        end else if (s_axi_araddr == `DCIB_ADDR_STARTS) begin
            rd_mux = {16'h0, starts_r};
        end else if (s_axi_araddr == `DCIB_ADDR_HOLD) begin
            rd_mux = {16'h0, hold_ms_r};
        end
    end

    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= `DCIB_RESP_OKAY;
            rdata_r  <= 32'h00000000;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= dcib_mapped(s_axi_araddr) ? `DCIB_RESP_OKAY : `DCIB_RESP_SLVERR;
            rdata_r  <= rd_mux;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp  = rresp_r;
    assign s_axi_rdata  = rdata_r;

    // ----------------------------------------
    // factory straps, caught once after reset
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            strap_s1_r <= 2'h0;
            strap_s2_r <= 2'h0;
        end else begin
            strap_s1_r <= {hall_current_sensor_strap, duty_heavy_strap};
            strap_s2_r <= strap_s1_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
            heavy_r      <= 1'b0;
            hall_r       <= 1'b0;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == `DCIB_STRAP_WAIT) begin
                strap_done_r <= 1'b1;
                heavy_r      <= strap_s2_r[0];
                hall_r       <= strap_s2_r[1];
            end
        end
    end

    // ----------------------------------------
    // hold interval from full-load current
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            hold_ms_r <= 16'(`DCIB_HOLD_P0);
        end else begin
            hold_ms_r <= dcib_hold_ms(fla_r);
        end
    end

    // ----------------------------------------
    // braking sequence
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dcib_pkg::DCIB_IDLE: begin
                if (ctrl_r[`DCIB_CTRL_RUN] && strap_done_r) begin
                    state_nxt = dcib_pkg::DCIB_RUN;
                end
            end
            dcib_pkg::DCIB_RUN: begin
                if (!ctrl_r[`DCIB_CTRL_RUN]) begin
                    state_nxt = ctrl_r[`DCIB_CTRL_DCSTOP] ? dcib_pkg::DCIB_DELAY
                                                          : dcib_pkg::DCIB_IDLE;
                end
            end
            dcib_pkg::DCIB_DELAY: begin
                if (tmr.done) begin
                    state_nxt = dcib_pkg::DCIB_INJECT;
                end
            end
            dcib_pkg::DCIB_INJECT: begin
                if (tmr.done) begin
                    state_nxt = dcib_pkg::DCIB_HOLD;
                end
            end
            dcib_pkg::DCIB_HOLD: begin
                if (tmr.done) begin
                    state_nxt = dcib_pkg::DCIB_IDLE;
                end
            end
            default: begin
                state_nxt = dcib_pkg::DCIB_IDLE;
            end
        endcase
    end

    always_comb begin
        tmr.load    = (state_nxt != state_r) && (state_nxt != dcib_pkg::DCIB_IDLE)
                      && (state_nxt != dcib_pkg::DCIB_RUN);
        tmr.load_ms = 16'h0000;
        if (state_nxt == dcib_pkg::DCIB_DELAY) begin
            tmr.load_ms = delay_ms_r;
        end else if (state_nxt == dcib_pkg::DCIB_INJECT) begin
            tmr.load_ms = time_ms_r;
        end else if (state_nxt == dcib_pkg::DCIB_HOLD) begin
            tmr.load_ms = hold_ms_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r <= dcib_pkg::DCIB_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            relay_r <= 1'b0;
            scr_r   <= 1'b0;
            motor_r <= 1'b0;
            extra_r <= 1'b0;
        end else begin
            relay_r <= (state_nxt == dcib_pkg::DCIB_DELAY) || (state_nxt == dcib_pkg::DCIB_INJECT)
                       || (state_nxt == dcib_pkg::DCIB_HOLD);
            scr_r   <= (state_nxt == dcib_pkg::DCIB_INJECT);
            motor_r <= (state_nxt == dcib_pkg::DCIB_RUN);
            extra_r <= (state_r == dcib_pkg::DCIB_RUN) && (state_nxt == dcib_pkg::DCIB_DELAY);
        end
    end

    // regulated current reference, clamped by brake duty
    assign level_lim = heavy_r ? `DCIB_LIM_HVY : `DCIB_LIM_STD;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            level_ref_r <= 10'h000;
        end else if (state_nxt == dcib_pkg::DCIB_INJECT) begin
            level_ref_r <= (level_r > level_lim) ? level_lim : level_r;
        end else begin
            level_ref_r <= 10'h000;
        end
    end

    assign brake_relay       = relay_r;
    assign scr_dc_on         = scr_r;
    assign dc_level_ref      = level_ref_r;
    assign motor_run         = motor_r;
    assign extra_start_pulse = extra_r;
    assign ol_use_running    = 1'b1;
    assign ol_duty_heavy     = heavy_r;
    assign ol_feedback_hall  = hall_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_SCR_NEEDS_RELAY: assert property (@(posedge clock) disable iff (!resetn)
        scr_r |-> relay_r)
        else $error("thyristors on without braking relay");
    AST_DELAY_FIRST: assert property (@(posedge clock) disable iff (!resetn)
        $rose(relay_r) |-> !scr_r ##1 !scr_r)
        else $error("injection started without delay");
    AST_STD_LIMIT: assert property (@(posedge clock) disable iff (!resetn)
        !heavy_r |-> level_ref_r <= `DCIB_LIM_STD)
        else $error("standard duty current above limit");
    AST_HVY_LIMIT: assert property (@(posedge clock) disable iff (!resetn)
        level_ref_r <= `DCIB_LIM_HVY && (scr_r || level_ref_r == 10'h000))
        else $error("heavy duty current above limit");
    AST_RELAY_HELD: assert property (@(posedge clock) disable iff (!resetn)
        $fell(scr_r) |-> relay_r && state_r == dcib_pkg::DCIB_HOLD)
        else $error("relay released with injection end");
    AST_EXTRA_START: assert property (@(posedge clock) disable iff (!resetn)
        $rose(relay_r) |-> extra_r ##1 !extra_r)
        else $error("braking stop not counted");
    AST_ORDINARY_STOP: assert property (@(posedge clock) disable iff (!resetn)
        state_r == dcib_pkg::DCIB_RUN && !ctrl_r[`DCIB_CTRL_RUN] && !ctrl_r[`DCIB_CTRL_DCSTOP]
        |=> state_r == dcib_pkg::DCIB_IDLE && !relay_r)
        else $error("plain stop did not go idle");
    AST_STRAPS_FIXED: assert property (@(posedge clock) disable iff (!resetn)
        strap_done_r && $past(strap_done_r) |-> $stable(heavy_r) && $stable(hall_r))
        else $error("factory configuration changed");
    AST_HOLD_END: assert property (@(posedge clock) disable iff (!resetn)
        state_r == dcib_pkg::DCIB_HOLD && tmr.done |=> state_r == dcib_pkg::DCIB_IDLE && !relay_r)
        else $error("hold end did not release relay");
    AST_HOLD_10A: assert property (@(posedge clock) disable iff (!resetn)
        $past(fla_r) <= `DCIB_FLA_P0 |-> hold_ms_r == `DCIB_HOLD_P0)
        else $error("hold interval wrong at low current");
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench of the dc injection brake sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ----------------------------------------
    // stimulus, bus tasks and checks
    // ----------------------------------------
    logic clock = 1'b0, resetn = 1'b0, clr = 1'b0, heavy = 1'b0, hall = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic brake_relay, scr_dc_on, motor_run, extra_start_pulse, ol_use_running, ol_duty_heavy, ol_feedback_hall;
    logic [9:0] dc_level_ref, lvl;
    int pre, inj, post, bad, num_errors = 0, n_tests = 0, cyc = 0;
    always #10 clock = ~clock;
    dcib_top #(.MS_CYCLES(4)) dut (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .duty_heavy_strap(heavy), .hall_current_sensor_strap(hall), .brake_relay(brake_relay),
        .scr_dc_on(scr_dc_on), .dc_level_ref(dc_level_ref), .motor_run(motor_run),
        .extra_start_pulse(extra_start_pulse), .ol_use_running(ol_use_running),
        .ol_duty_heavy(ol_duty_heavy), .ol_feedback_hall(ol_feedback_hall));
    dcib_motor_model motor (.clock(clock), .clr(clr), .brake_relay(brake_relay), .scr_dc_on(scr_dc_on),
        .dc_level_ref(dc_level_ref), .extra_start_pulse(extra_start_pulse), .pre_cnt(pre),
        .inj_cnt(inj), .post_cnt(post), .lvl(lvl), .bad(bad));
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            num_errors++;
            print_verdict();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_s, w_s, b_s;
        logic [1:0] r;
        int n;
        b_s = 1'b0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!b_s && n < 100) begin
            @(negedge clock);
            aw_s = awvalid && awready;
            w_s = wvalid && wready;
            b_s = bvalid;
            r = bresp;
            @(posedge clock);
            if (aw_s) awvalid <= 1'b0;
            if (w_s) wvalid <= 1'b0;
            n++;
        end
        chk({30'h0, r}, {30'h0, er});
    endtask
    task rc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_s, r_s;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        r_s = 1'b0;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!r_s && n < 100) begin
            @(negedge clock);
            ar_s = arvalid && arready;
            r_s = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (ar_s) arvalid <= 1'b0;
            n++;
        end
        chk(d, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task wt(input logic v);
        int n;
        n = 0;
        @(negedge clock);
        while (brake_relay !== v && n < 5000) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
    endtask
    task brake(input logic [9:0] el, input int hold_ms);
        wc(8'h04, 32'h3, 2'h0);
        wc(8'h08, 32'h5, 2'h0);
        wc(8'h0c, 32'h1c2, 2'h0);
        clr <= 1'b1;
        wc(8'h00, 32'h3, 2'h0);
        clr <= 1'b0;
        wc(8'h00, 32'h2, 2'h0);
        wt(1'b1);
        wt(1'b0);
        chk(32'(pre), 32'd14);
        chk(32'(inj), 32'd22);
        chk(32'(post), 32'(hold_ms * 4 + 2));
        chk({22'h0, lvl}, {22'h0, el});
        chk(32'(bad), 32'd0);
        rc(8'h18, 32'h1, 2'h0);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        rc(8'h04, 32'h64, 2'h0);
        rc(8'h08, 32'h3e8, 2'h0);
        rc(8'h0c, 32'hc8, 2'h0);
        rc(8'h1c, 32'h190, 2'h0);
        rc(8'h20, 32'h0, 2'h2);
        chk({31'h0, ol_use_running}, 32'h1);
        $display("test reset done");
        wc(8'h10, 32'h64, 2'h0);
        rc(8'h1c, 32'h320, 2'h0);
        brake(10'h0fa, 800);
        wc(8'h18, 32'h0, 2'h0);
        clr <= 1'b1;
        wc(8'h00, 32'h1, 2'h0);
        clr <= 1'b0;
        @(negedge clock);
        chk({31'h0, motor_run}, 32'h1);
        @(posedge clock);
        wc(8'h00, 32'h0, 2'h0);
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk({31'h0, motor_run}, 32'h0);
        chk(32'(pre), 32'd0);
        @(posedge clock);
        rc(8'h18, 32'h0, 2'h0);
        $display("test standard brake and plain stop done");
        resetn <= 1'b0;
        heavy <= 1'b1;
        hall <= 1'b1;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        repeat (8) @(posedge clock);
        rc(8'h14, 32'h300, 2'h0);
        chk({30'h0, ol_duty_heavy, ol_feedback_hall}, 32'h3);
        brake(10'h190, 400);
        $display("test heavy brake done");
        print_verdict();
    end
endmodule
`default_nettype wire
